// *** hdl/eepc_pkg.sv ***
package eepc_pkg;
    // Command frame
    localparam logic [3:0] START_PAT = 4'ha;
    localparam logic [3:0] OP_READ = 4'h8;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_ENABLE_WRITES_CMD = 4'h3;
    localparam logic [3:0] OP_DISABLE_WRITES_CMD = 4'h0;
    localparam int WORD_BITS = 16;
    localparam int ADDR_SLOTS = 8;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_START_END = 6'h03;
    localparam logic [5:0] CNT_OP_END = 6'h07;
    localparam logic [5:0] CNT_ADDR0 = 6'h08;
    localparam logic [5:0] CNT_CMD_END = 6'h0f;
    localparam logic [5:0] CNT_DATA0 = 6'h10;
    localparam logic [5:0] CNT_WR_END = 6'h1f;
    localparam logic [5:0] CNT_RD_END = 6'h10;
    // Synchronised pin vector: cs_n, sck, sdi, guard
    localparam int PIN_CS = 3;
    localparam int PIN_SK = 2;
    localparam int PIN_DI = 1;
    localparam int PIN_WG = 0;
    localparam logic [3:0] PIN_RST = 4'h8;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 10000000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int SV_TIME_NS = 1000;
    localparam int SV_CYCLES = SV_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 18;
    localparam int FIFO_DEPTH = 16;
    // States
    typedef enum logic [2:0] {S_IDLE, S_CMD, S_READ, S_POST, S_DONE} eepc_state_t;
    typedef enum logic [1:0] {W_IDLE, W_SV, W_PROG} eepc_wstate_t;
endpackage : eepc_pkg

// *** hdl/eepc_stream_if.sv ***
`timescale 1ns/100ps
interface eepc_stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : eepc_stream_if

// *** hdl/eepc_sync.sv ***
`timescale 1ns/100ps
module eepc_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_reg <= RST;
            q_out <= RST;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule : eepc_sync

// *** hdl/eepc_fifo.sv ***
`timescale 1ns/100ps
module eepc_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Streams
    eepc_stream_if.snk wr,
    eepc_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic do_wr;
    logic do_rd;

    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data = mem[rp_reg];
    assign do_wr = wr.valid & wr.ready;
    assign do_rd = rd.valid & rd.ready;

    always_ff @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wp_reg] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_wr) begin
                wp_reg <= wp_reg + AW'(1);
            end
            if (do_rd) begin
                rp_reg <= rp_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : eepc_fifo

// *** hdl/eepc_port.sv ***
// Function
// [R1] Frame is start 1010, four-bit opcode, then address and optional data.
// [R2] Address sent A0 first; eight slots, top slot unused on small device.
// [R3] Write data follows address, sixteen bits, D0 first.
// [R4] Write-enable latch is cleared at power-up.
// [R5] Write-enable latch stays set until a disable command is accepted.
// [R6] Enable and disable ignore clock pulses after the sixteenth.
// [R7] Write guard level ignored during enable and disable commands.
// [R8] After opcode, chip select going inactive does not cancel the command.
// [R9] Read word shifts out after sixteenth clock, changing on falling edges.
// [R10] Host samples read data after output delay following falling edge.
// [R11] Chip select low while write shifts in; ignored once write runs.
// [R12] Guard high during cell write aborts it; word left undefined.
// [R13] After write, new command needs chip select high then falling.
// [R14] Ready goes low status delay after rising edge of 32nd clock.
// [R15] Last data bit edge starts self-timed write; clock ignored meanwhile.
// [R16] No new command accepted while the cell write runs.
// [R17] Chip select falling with clock low after write shows status on output.
// [R18] Ready output shows internal status: low writing, high standby.
// [R19] Chip select raised abandons pending operation regardless of guard.
// [R20] Guard high before cell is altered aborts write, word unchanged.
// [R21] Chip select raised while ready resets command logic.
// [R22] Input sampled on rising clock edges, output changed on falling.
// [R23] Host holds chip select high minimum time between commands.
// [R24] Write guard affects only write commands.
// [R25] Serial output is released when not shifting data or status.
`timescale 1ns/100ps
module eepc_port import eepc_pkg::*; #(
    parameter int ADDR_BITS = 8,
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int SV_CYC = SV_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Serial pins
    input wire logic chip_select_n_in,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic write_guard_in,
    // Outputs
    output logic serial_out_out,
    output logic serial_out_oe_n_out,
    output logic ready_out
);
    localparam int QW = ADDR_SLOTS + WORD_BITS;

    typedef struct packed {
        eepc_state_t st;
        eepc_wstate_t wst;
        logic [CNT_W-1:0] cnt;
        logic [7:0] hdr;
        logic [3:0] op;
        logic [ADDR_SLOTS-1:0] addr;
        logic [WORD_BITS-1:0] sh;
        logic wel;
        logic dout;
        logic doe_n;
        logic rdy;
        logic skp;
        logic csp;
        logic push;
        logic [TMR_W-1:0] tmr;
        logic [ADDR_SLOTS-1:0] wad;
        logic [WORD_BITS-1:0] wdat;
        logic mwr;
        logic [WORD_BITS-1:0] mval;
    } eepc_regs_t;

    eepc_regs_t s_reg;
    eepc_regs_t s_next;
    logic [WORD_BITS-1:0] mem [2**ADDR_BITS];
    logic [3:0] pins;
    logic cs;
    logic sk;
    logic di;
    logic wg;
    logic sk_rise;
    logic sk_fall;
    logic cs_fall;
    logic cs_rise;
    logic busy;
    logic [2:0] a_idx;
    logic [3:0] d_idx;
    logic [3:0] o_idx;

    eepc_stream_if #(.W(QW)) push_if ();
    eepc_stream_if #(.W(QW)) pop_if ();

    // Pins are asynchronous to the system clock
    eepc_sync #(.W(4), .RST(PIN_RST)) u_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .d_in({chip_select_n_in, serial_clock_in, serial_in, write_guard_in}),
        .q_out(pins)
    );

    eepc_fifo #(.W(QW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    assign cs = pins[PIN_CS];
    assign sk = pins[PIN_SK];
    assign di = pins[PIN_DI];
    assign wg = pins[PIN_WG];
    assign sk_rise = sk & ~s_reg.skp; // R22
    assign sk_fall = ~sk & s_reg.skp; // R22
    assign cs_fall = ~cs & s_reg.csp;
    assign cs_rise = cs & ~s_reg.csp;
    assign busy = (s_reg.wst != W_IDLE) | pop_if.valid | s_reg.push;
    assign a_idx = 3'(s_reg.cnt - CNT_ADDR0);
    assign d_idx = 4'(s_reg.cnt - CNT_DATA0);
    assign o_idx = s_reg.cnt[3:0];

    assign push_if.valid = s_reg.push;
    assign push_if.data = {s_reg.addr, s_reg.sh};
    // Writer takes one word at a time, so the queue back-pressures the port
    assign pop_if.ready = (s_reg.wst == W_IDLE);

    assign serial_out_out = s_reg.dout;
    assign serial_out_oe_n_out = s_reg.doe_n;
    assign ready_out = s_reg.rdy;

    always_comb begin
        s_next = s_reg;
        s_next.skp = sk;
        s_next.csp = cs;
        s_next.push = 1'b0;
        s_next.mwr = 1'b0;
        unique case (s_reg.st)
            S_IDLE: begin
                s_next.doe_n = 1'b1; // R25
                if (cs_fall) begin
                    s_next.cnt = '0;
                    s_next.st = busy ? S_DONE : S_CMD; // R16
                end
            end
            S_CMD: begin
                if (cs_rise && s_reg.cnt <= CNT_OP_END) begin
                    s_next.st = S_IDLE; // R19
                    s_next.doe_n = 1'b1;
                end else if (cs_fall && s_reg.cnt > CNT_OP_END) begin
                    s_next.cnt = '0; // R8
                end else if (sk_rise && !cs) begin
                    s_next.cnt = s_reg.cnt + 6'h01;
                    s_next.hdr = {s_reg.hdr[6:0], di};
                    if (s_reg.cnt == CNT_START_END && {s_reg.hdr[2:0], di} != START_PAT) begin
                        s_next.st = S_DONE; // R1
                    end
                    if (s_reg.cnt == CNT_OP_END) begin
                        s_next.op = {s_reg.hdr[2:0], di}; // R1
                        if (!({s_reg.hdr[2:0], di} inside {OP_READ, OP_WRITE, OP_ENABLE_WRITES_CMD, OP_DISABLE_WRITES_CMD})) begin
                            s_next.st = S_DONE;
                        end
                    end
                    if (s_reg.cnt >= CNT_ADDR0 && s_reg.cnt <= CNT_CMD_END) begin
                        s_next.addr[a_idx] = di; // R2
                    end
                    if (s_reg.cnt >= CNT_DATA0) begin
                        s_next.sh[d_idx] = di; // R3
                    end
                    if (s_reg.cnt == CNT_CMD_END) begin
                        unique case (s_reg.op)
                            OP_ENABLE_WRITES_CMD: begin
                                s_next.wel = 1'b1; // R5 R7 R24
                                s_next.st = S_DONE; // R6
                            end
                            OP_DISABLE_WRITES_CMD: begin
                                s_next.wel = 1'b0; // R5 R7
                                s_next.st = S_DONE; // R6
                            end
                            OP_READ: begin
                                s_next.sh = mem[s_next.addr[ADDR_BITS-1:0]];
                                s_next.cnt = '0;
                                s_next.st = S_READ;
                            end
                            default: begin
                            end
                        endcase
                    end
                    if (s_reg.cnt == CNT_WR_END) begin
                        // Guard and latch gate only the write
                        if (s_reg.wel && !wg && push_if.ready) begin // R24
                            s_next.push = 1'b1; // R15
                            s_next.st = S_POST;
                        end else begin
                            s_next.st = S_DONE;
                        end
                    end
                end
            end
            S_READ: begin
                if (cs_rise) begin
                    s_next.doe_n = 1'b1; // R19 R25
                    s_next.st = S_IDLE;
                end else if (sk_fall && s_reg.cnt < CNT_RD_END) begin
                    s_next.dout = s_reg.sh[o_idx]; // R9
                    s_next.doe_n = 1'b0;
                    s_next.cnt = s_reg.cnt + 6'h01;
                end
            end
            S_POST: begin // R11 R15
                // Clock and chip select do not disturb the running write
                if (!s_reg.doe_n) begin
                    s_next.dout = s_reg.rdy; // R17
                end
                if (cs_rise) begin
                    s_next.doe_n = 1'b1;
                    if (!busy) begin
                        s_next.st = S_IDLE; // R21
                    end
                end else if (cs_fall) begin
                    // Status shows even when the new frame is taken at once
                    if (!sk) begin
                        s_next.doe_n = 1'b0; // R17
                        s_next.dout = s_reg.rdy;
                    end
                    if (!busy) begin
                        s_next.cnt = '0; // R13
                        s_next.st = S_CMD;
                    end
                end
            end
            S_DONE: begin
                s_next.doe_n = 1'b1;
                if (cs_rise) begin
                    s_next.st = S_IDLE; // R13
                end
            end
            default: begin
                s_next.st = S_IDLE;
            end
        endcase
        // Self-timed cell writer
        unique case (s_reg.wst)
            W_IDLE: begin
                if (pop_if.valid) begin
                    s_next.wad = pop_if.data[QW-1:WORD_BITS];
                    s_next.wdat = pop_if.data[WORD_BITS-1:0];
                    s_next.tmr = '0;
                    s_next.wst = W_SV;
                end
            end
            W_SV: begin
                s_next.tmr = s_reg.tmr + 18'h00001;
                if (wg) begin
                    s_next.wst = W_IDLE; // R20
                end else if (s_reg.tmr == TMR_W'(SV_CYC - 1)) begin
                    s_next.tmr = '0;
                    s_next.wst = W_PROG; // R14
                end
            end
            W_PROG: begin
                s_next.tmr = s_reg.tmr + 18'h00001;
                if (wg) begin
                    // Erase already done, program cut short
                    s_next.mwr = 1'b1; // R12
                    s_next.mval = '1;
                    s_next.wst = W_IDLE;
                end else if (s_reg.tmr == TMR_W'(WRITE_CYC - 1)) begin
                    s_next.mwr = 1'b1; // R15
                    s_next.mval = s_reg.wdat;
                    s_next.wst = W_IDLE;
                end
            end
            default: begin
                s_next.wst = W_IDLE;
            end
        endcase
        s_next.rdy = (s_next.wst != W_PROG); // R18
    end

    always_ff @(posedge clk_sys_in) begin
        if (s_reg.mwr) begin
            mem[s_reg.wad[ADDR_BITS-1:0]] <= s_reg.mval;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_reg <= '{st: S_IDLE, wst: W_IDLE, doe_n: 1'b1, rdy: 1'b1, skp: 1'b0,
                       csp: 1'b1, default: '0}; // R4
        end else begin
            s_reg <= s_next;
        end
    end

    wel_set_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R5
        $rose(s_reg.wel) |-> $past(s_reg.op) == OP_ENABLE_WRITES_CMD && $past(s_reg.st) == S_CMD)
        else $error("write latch set without enable command");
    wel_clear_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R5
        $fell(s_reg.wel) |-> $past(s_reg.op) == OP_DISABLE_WRITES_CMD)
        else $error("write latch cleared without disable command");
    busy_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R16
        (s_reg.st == S_IDLE && cs_fall && busy) |=> s_reg.st == S_DONE)
        else $error("command accepted while busy");
    ready_fall_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R14
        $fell(ready_out) |-> $past(s_reg.wst) == W_SV && $past(s_reg.tmr) == TMR_W'(SV_CYC - 1))
        else $error("ready fell without status delay");
    guard_abort_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R12
        (s_reg.wst == W_PROG && wg) |=> s_reg.wst == W_IDLE && s_reg.mwr && ready_out)
        else $error("guard did not abort cell write");
    pre_abort_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R20
        (s_reg.wst == W_SV && wg) |=> s_reg.wst == W_IDLE && !s_reg.mwr)
        else $error("guard did not cancel pending write");
    write_start_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R15
        s_reg.push |-> ##[1:3] s_reg.wst == W_SV)
        else $error("cell write not started");
    read_drive_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R9
        (s_reg.st == S_READ && sk_fall && !cs_rise && s_reg.cnt < CNT_RD_END)
        |=> !serial_out_oe_n_out && serial_out_out == $past(s_reg.sh[o_idx]))
        else $error("read bit not driven on falling edge");
    idle_release_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R25
        (s_reg.st == S_IDLE) |=> serial_out_oe_n_out || s_reg.st != S_IDLE)
        else $error("output driven while idle");
    ignore_clock_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R6
        (s_reg.st == S_DONE && !cs_rise) |=> s_reg.st == S_DONE)
        else $error("clocks after command end not ignored");
    // Pins are sampled into this clock, so every check below stays in one domain
    post_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R16
        (s_reg.st == S_POST && cs_fall && busy) |=> s_reg.st == S_POST)
        else $error("command taken during cell write");
    cmd_restart_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R8
        (s_reg.st == S_CMD && cs_fall && s_reg.cnt > CNT_OP_END) |=> s_reg.st == S_CMD && s_reg.cnt == '0)
        else $error("frame not restarted on new select");
    early_cancel_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R19
        (s_reg.st == S_CMD && cs_rise && s_reg.cnt <= CNT_OP_END) |=> s_reg.st == S_IDLE)
        else $error("frame not dropped before opcode");
    read_release_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R25
        (s_reg.st == S_READ && cs_rise) |=> serial_out_oe_n_out && s_reg.st == S_IDLE)
        else $error("output not released after read");
    status_show_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R17
        (s_reg.st == S_POST && cs_fall && !sk)
        |=> !serial_out_oe_n_out && serial_out_out == $past(s_reg.rdy))
        else $error("status not shown on data output");
    write_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R4
        (s_reg.st == S_CMD && sk_rise && !cs && !cs_fall && s_reg.cnt == CNT_WR_END && !s_reg.wel)
        |=> !s_reg.push && s_reg.st == S_DONE)
        else $error("write accepted with latch clear");
    ready_rise_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R18
        $rose(ready_out) |-> s_reg.mwr)
        else $error("ready returned without cell update");
endmodule : eepc_port

// *** dv/eepc_host_model.sv ***
`timescale 1ns/100ps
module eepc_host_model import eepc_pkg::*; (
    // Clock
    input wire logic clk_sys_in,
    // Device pins
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out,
    output logic guard_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_n_in,
    // Read results
    output logic [15:0] rd_word_out,
    output logic rd_driven_out,
    output logic rd_done_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
        guard_out = 1'b0;
        rd_word_out = 16'h0000;
        rd_driven_out = 1'b0;
        rd_done_out = 1'b0;
    end

    function automatic logic [15:0] rev(input logic [15:0] v, input int n);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < n; i++)
            r[n - 1 - i] = v[i];
        return r;
    endfunction : rev

    // Half period of the 400 ns link clock, pins change on falling system edges
    task automatic half();
        repeat (4) @(negedge clk_sys_in);
    endtask : half

    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_out = v[i];
            half();
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
    endtask : send

    task automatic select();
        cs_n_out = 1'b0;
        half();
    endtask : select

    // Clock low, chip select high and the data input inverted, then a gap of 24 system clocks
    task automatic deselect();
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
        repeat (24) @(negedge clk_sys_in);
    endtask : deselect

    task automatic command(input logic [3:0] op, input logic g, input int extra,
                           input logic [7:0] fill);
        guard_out = g;
        select();
        send({16'h0000, START_PAT, op, fill}, 16);
        send({24'h000000, fill}, extra);
        deselect();
        guard_out = 1'b0;
    endtask : command

    task automatic write_word(input logic [7:0] a, input logic [15:0] d, input int g_at);
        logic [15:0] ra;
        ra = rev({8'h00, a}, 8);
        select();
        send({16'h0000, START_PAT, OP_WRITE, ra[7:0]}, 16);
        send({16'h0000, rev(d, 16)}, 16);
        if (g_at > 0) begin
            repeat (g_at) @(negedge clk_sys_in);
            guard_out = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            guard_out = 1'b0;
        end
        deselect();
    endtask : write_word

    task automatic read_word(input logic [7:0] a);
        logic [15:0] ra;
        logic [15:0] w;
        logic drv;
        ra = rev({8'h00, a}, 8);
        w = 16'h0000;
        drv = 1'b1;
        select();
        send({16'h0000, START_PAT, OP_READ, ra[7:0]}, 16);
        for (int i = 0; i < 16; i++) begin
            half();
            // A released line reads as the inverse so a stale bit cannot pass
            w[i] = (sdo_oe_n_in === 1'b0) ? sdo_in : ~sdo_in;
            drv = drv & (sdo_oe_n_in === 1'b0);
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
        deselect();
        rd_word_out = w;
        rd_driven_out = drv;
        rd_done_out = 1'b1;
        @(negedge clk_sys_in);
        rd_done_out = 1'b0;
    endtask : read_word
endmodule : eepc_host_model

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench import eepc_pkg::*;;
    localparam int WR_CYC = 200;
    logic clk_sys_in;
    logic resetn_in;
    logic cs_n, sck, sdi, guard, sdo, sdo_oe_n, ready;
    logic [15:0] rd_word;
    logic rd_driven, rd_done;
    logic [15:0] exp_q[$];
    logic [15:0] mem [0:255];
    logic [7:0] a;
    logic [15:0] d;
    int error_cnt = 0;
    int cmp_count = 0;
    int low_cnt = 0;
    integer seed;

    eepc_port #(.WRITE_CYC(WR_CYC)) uut (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .chip_select_n_in(cs_n),
        .serial_clock_in(sck),
        .serial_in(sdi),
        .write_guard_in(guard),
        .serial_out_out(sdo),
        .serial_out_oe_n_out(sdo_oe_n),
        .ready_out(ready)
    );

    eepc_host_model host (
        .clk_sys_in(clk_sys_in),
        .cs_n_out(cs_n),
        .sck_out(sck),
        .sdi_out(sdi),
        .guard_out(guard),
        .sdo_in(sdo),
        .sdo_oe_n_in(sdo_oe_n),
        .rd_word_out(rd_word),
        .rd_driven_out(rd_driven),
        .rd_done_out(rd_done)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        if (ready === 1'b0)
            low_cnt++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // Oldest expected word against each finished read
    always @(posedge rd_done) begin
        check(rd_word, exp_q.pop_front());
        check({15'h0000, rd_driven}, 16'h0001);
    end

    task automatic rd(input logic [7:0] ra);
        exp_q.push_back(mem[ra]);
        host.read_word(ra);
    endtask : rd

    // kind 0: refused or aborted before programming, 1: full write, 2: cut short
    task automatic wr(input logic [7:0] wa, input logic [15:0] wd, input int g_at,
                      input int kind);
        low_cnt = 0;
        host.write_word(wa, wd, g_at);
        repeat (300) @(negedge clk_sys_in);
        check({15'h0000, ready}, 16'h0001);
        if (kind == 2) begin
            check({15'h0000, low_cnt > 0 && low_cnt < WR_CYC}, 16'h0001);
            mem[wa] = 16'hffff;
        end else begin
            check(low_cnt[15:0], (kind == 1) ? WR_CYC[15:0] : 16'h0000);
            if (kind == 1)
                mem[wa] = wd;
        end
    endtask : wr

    initial begin
        repeat (40000) @(posedge clk_sys_in);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        seed = 32'h4fcfec05;
        resetn_in = 1'b0;
        repeat (20) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check({14'h0000, ready, sdo_oe_n}, 16'h0003);
        wr(8'h09, 16'h5555, 0, 0);
        host.command(OP_ENABLE_WRITES_CMD, 1'b1, 4, 8'($random(seed)));
        wr(8'h09, 16'ha5c3, 0, 1);
        wr(8'h89, 16'h3c5a, 0, 1);
        for (int i = 0; i < 4; i++) begin
            a = {3'b001, i[1:0], 3'($random(seed))};
            d = 16'($random(seed));
            wr(a, d, 0, 1);
            rd(a);
        end
        rd(8'h09);
        rd(8'h89);
        wr(8'h44, 16'h1111, 0, 1);
        wr(8'h44, 16'h2222, 1, 0);
        rd(8'h44);
        wr(8'h44, 16'h2222, 100, 2);
        rd(8'h44);
        // Status shown on the data output while the cell write runs
        low_cnt = 0;
        host.write_word(8'h45, 16'h7e81, 0);
        host.select();
        repeat (4) @(negedge clk_sys_in);
        check({14'h0000, sdo_oe_n, sdo}, 16'h0000);
        repeat (250) @(negedge clk_sys_in);
        check({14'h0000, sdo_oe_n, sdo}, 16'h0001);
        check(low_cnt[15:0], WR_CYC[15:0]);
        host.deselect();
        mem[8'h45] = 16'h7e81;
        rd(8'h45);
        host.command(OP_DISABLE_WRITES_CMD, 1'b0, 0, 8'($random(seed)));
        wr(8'h09, 16'h0000, 0, 0);
        rd(8'h09);
        // Wrong start pattern leaves the output released
        host.select();
        host.send(32'h00005800, 16);
        host.send(32'h00000000, 16);
        check({15'h0000, sdo_oe_n}, 16'h0001);
        host.deselect();
        // Read abandoned by chip select
        host.select();
        host.send({16'h0000, START_PAT, OP_READ, 8'h90}, 16);
        repeat (6) @(negedge clk_sys_in);
        check({15'h0000, sdo_oe_n}, 16'h0000);
        host.deselect();
        check({15'h0000, sdo_oe_n}, 16'h0001);
        // Frame cut inside the opcode is dropped
        host.select();
        host.send(32'h0000002a, 6);
        host.deselect();
        check({15'h0000, sdo_oe_n}, 16'h0001);
        // Opcode taken: chip select high does not cancel, a new fall restarts the frame
        host.select();
        host.send({24'h000000, START_PAT, OP_READ}, 8);
        host.deselect();
        rd(8'h89);
        repeat (20) @(negedge clk_sys_in);
        end_of_test();
    end
endmodule : testbench
